// ---- hw/bbsp_pkg.sv ----
package bbsp_pkg;
  // ********************************************************
  // timing in ns, recovery in us, at the 125 MHz system clock
  // ********************************************************
  localparam int CLK_PERIOD_NS    = 8;
  localparam int T_HOLD_OFF_NS    = 10;   // strobe high before next access
  localparam int T_DATA_SETUP_NS  = 50;   // data valid before write end
  localparam int T_DATA_HOLD_NS   = 5;    // data kept after write end
  localparam int T_STROBE_NS      = 80;   // strobe pulse and address setup
  localparam int T_READ_NS        = 100;  // address access time
  localparam int T_OE_OFF_NS      = 40;   // output enable high to bus free
  localparam int T_RECOVERY_US    = 1000; // recovery_delay, 1 ms

  // least times round up
  localparam int HOLD_OFF_CYC   = (T_HOLD_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_SETUP_CYC = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_HOLD_CYC  = (T_DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC     = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC       = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OE_OFF_CYC     = (T_OE_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC   = (T_RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 18;

  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
endpackage : bbsp_pkg

// ---- hw/bbsp_sync.sv ----
`timescale 1ns/100ps
// ********************************************************
// two-flop synchroniser for a pin level
// ********************************************************
module bbsp_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic meta;
    logic sync;
  } bbsp_sync_st_t;

  bbsp_sync_st_t s_q;
  bbsp_sync_st_t s_d;

  // reset to idle high, since the alert pin is pulled up
  always_comb begin
    s_d      = s_q;
    s_d.meta = din;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.sync;
endmodule : bbsp_sync

// ---- hw/bbsp_ctrl.sv ----
`timescale 1ns/100ps
module bbsp_ctrl
  import bbsp_pkg::*;
#(
  parameter int RECOVERY_CYCLES = RECOVERY_CYC
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // user side
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire logic                       req_write,
  input  wire logic [bbsp_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [bbsp_pkg::DATA_W-1:0] req_wdata,
  output logic                            rsp_valid,
  output logic      [bbsp_pkg::DATA_W-1:0] rsp_rdata,
  output logic                            power_ok,
  // memory pins
  output logic      [bbsp_pkg::ADDR_W-1:0] mem_addr,
  output logic                            chip_sel_one_n,
  output logic                            chip_sel_two,
  output logic                            out_en_n,
  output logic                            write_n,
  input  wire logic [bbsp_pkg::DATA_W-1:0] byte_lines_i,
  output logic      [bbsp_pkg::DATA_W-1:0] byte_lines_o,
  output logic                            byte_lines_oe,
  input  wire logic                       alert_n_i
);
  import bbsp_pkg::*;

  typedef enum logic [2:0] {
    ST_RECOVER, ST_IDLE, ST_WSETUP, ST_WSTROBE, ST_WHOLD, ST_RSTROBE, ST_ROFF, ST_GAP
  } bbsp_state_t;

  typedef struct packed {
    bbsp_state_t          st;
    logic [CNT_W-1:0]     cnt;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    wdata;
    logic                 drive;
    logic                 sel;
    logic                 oe_n;
    logic                 we_n;
    logic                 rsp;
    logic [DATA_W-1:0]    rdata;
  } bbsp_st_t;

  bbsp_st_t s_q;
  bbsp_st_t s_d;
  logic     alert_n;
  logic     alert_sync_n;
  logic [DATA_W-1:0] bytes_meta_q;
  logic [DATA_W-1:0] bytes_sync_q;

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  bbsp_sync u_alert_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (alert_n_i),
    .dout    (alert_sync_n)
  );
  assign alert_n = alert_sync_n; // pull-up assumed on the board

  // read data is sampled only after access time, two flops still kept
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bytes_meta_q <= DATA_RST;
      bytes_sync_q <= DATA_RST;
    end else begin
      bytes_meta_q <= byte_lines_i;
      bytes_sync_q <= bytes_meta_q;
    end
  end

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction : cyc

  // ********************************************************
  // access sequencer
  // ********************************************************
  always_comb begin
    s_d     = s_q;
    s_d.rsp = 1'b0;
    if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    case (s_q.st)
      ST_RECOVER: begin
        s_d.sel  = 1'b0;
        s_d.we_n = 1'b1;
        s_d.oe_n = 1'b1;
        if (!alert_n) begin
          s_d.cnt = cyc(RECOVERY_CYCLES); // restart on every alert
        end else if (s_q.cnt == '0) begin
          s_d.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!alert_n) begin
          s_d.st  = ST_RECOVER;
          s_d.cnt = cyc(RECOVERY_CYCLES);
        end else if (req_valid) begin
          s_d.addr  = req_addr;
          s_d.wdata = req_wdata;
          s_d.oe_n  = 1'b1;
          if (req_write) begin
            s_d.st    = ST_WSETUP;
            s_d.drive = 1'b1;
            s_d.sel   = 1'b1;
            s_d.cnt   = '0;
          end else begin
            s_d.st  = ST_RSTROBE;
            s_d.sel = 1'b1;
            s_d.cnt = cyc(READ_CYC + 2);
          end
        end
      end
      ST_WSETUP: begin
        // address and selects settle one cycle before the strobe falls
        s_d.st   = ST_WSTROBE;
        s_d.we_n = 1'b0;
        s_d.cnt  = cyc(STROBE_CYC > DATA_SETUP_CYC ? STROBE_CYC : DATA_SETUP_CYC);
      end
      ST_WSTROBE: begin
        if (s_q.cnt == '0) begin
          s_d.st   = ST_WHOLD;
          s_d.we_n = 1'b1;
          s_d.cnt  = cyc(DATA_HOLD_CYC);
        end
      end
      ST_WHOLD: begin
        if (s_q.cnt == '0) begin
          s_d.st    = ST_GAP;
          s_d.drive = 1'b0;
          s_d.sel   = 1'b0;
          s_d.cnt   = cyc(HOLD_OFF_CYC);
          s_d.rsp   = 1'b1;
        end
      end
      ST_RSTROBE: begin
        s_d.oe_n = 1'b0;
        if (s_q.cnt == '0) begin
          s_d.rdata = bytes_sync_q;
          s_d.rsp   = 1'b1;
          s_d.oe_n  = 1'b1;
          s_d.sel   = 1'b0;
          s_d.st    = ST_ROFF;
          s_d.cnt   = cyc(OE_OFF_CYC);
        end
      end
      ST_ROFF: begin
        if (s_q.cnt == '0) begin
          s_d.st  = ST_GAP;
          s_d.cnt = cyc(HOLD_OFF_CYC);
        end
      end
      ST_GAP: begin
        if (s_q.cnt == '0) begin
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_RECOVER;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q       <= '0;
      s_q.st    <= ST_RECOVER;
      s_q.cnt   <= CNT_W'(RECOVERY_CYCLES - 1);
      s_q.oe_n  <= 1'b1;
      s_q.we_n  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign req_ready      = (s_q.st == ST_IDLE) && alert_n;
  assign rsp_valid      = s_q.rsp;
  assign rsp_rdata      = s_q.rdata;
  assign power_ok       = (s_q.st != ST_RECOVER);
  assign mem_addr       = s_q.addr;
  assign chip_sel_one_n = ~s_q.sel;
  assign chip_sel_two   = s_q.sel;
  assign out_en_n       = s_q.oe_n;
  assign write_n        = s_q.we_n;
  assign byte_lines_o   = s_q.wdata;
  assign byte_lines_oe  = s_q.drive;

  // ********************************************************
  // checks
  // ********************************************************
  property p_strobe_width;
    @(posedge clk_sys) disable iff (rst)
      $fell(write_n) |-> write_n == 1'b0 [*7];
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe too short");

  property p_addr_stable;
    @(posedge clk_sys) disable iff (rst)
      !write_n |=> $stable(mem_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in write");

  property p_oe_high_write;
    @(posedge clk_sys) disable iff (rst)
      byte_lines_oe |-> out_en_n;
  endproperty
  a_oe_high_write: assert property (p_oe_high_write) else $error("bus contention");

  sequence s_write_end;
    $rose(write_n);
  endsequence
  property p_data_hold;
    @(posedge clk_sys) disable iff (rst)
      s_write_end |-> byte_lines_oe && $stable(byte_lines_o);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held");

  property p_gap;
    @(posedge clk_sys) disable iff (rst)
      $fell(chip_sel_two) |-> !chip_sel_two [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("select gap too short");

  property p_desel_recover;
    @(posedge clk_sys) disable iff (rst)
      !power_ok |-> chip_sel_one_n && !chip_sel_two;
  endproperty
  a_desel_recover: assert property (p_desel_recover) else $error("selected in recovery");

  // an alert seen while idle must close the port before any request is taken
  property p_no_write_alert;
    @(posedge clk_sys) disable iff (rst)
      (!alert_n && s_q.st == ST_IDLE) |=> !power_ok && !req_ready;
  endproperty
  a_no_write_alert: assert property (p_no_write_alert) else $error("accepted under alert");

  property p_sel_with_strobe;
    @(posedge clk_sys) disable iff (rst)
      !write_n |-> !chip_sel_one_n && chip_sel_two;
  endproperty
  a_sel_with_strobe: assert property (p_sel_with_strobe) else $error("strobe without select");
endmodule : bbsp_ctrl

// ---- test/bbsp_sram_model.sv ----
`timescale 1ns/100ps
// ************************************************
// byte-wide memory with power-fail alert
// ************************************************
module bbsp_sram_model
  import bbsp_pkg::*;
#(
  // half a clock off the edge, so the pin never races the sampling flops
  parameter int T_DESEL_NS = 10004,
  parameter int T_REL_NS   = 1004
) (
  input  wire logic [bbsp_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic                        chip_sel_one_n,
  input  wire logic                        chip_sel_two,
  input  wire logic                        out_en_n,
  input  wire logic                        write_n,
  input  wire logic [bbsp_pkg::DATA_W-1:0] byte_lines_o,
  input  wire logic                        byte_lines_oe,
  input  wire logic                        power_fail,
  output logic      [bbsp_pkg::DATA_W-1:0] byte_lines_i,
  output logic                             alert_n
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last_q = 8'h00;
  logic              off_q = 1'b0;
  logic              alert_low_q = 1'b0;
  logic              wr_act;
  logic              rd_on;

  // write window is the overlap of all three strobes
  assign wr_act = !write_n && !chip_sel_one_n && chip_sel_two && !off_q;
  // data is taken as it stands when the first strobe lets go
  always @(negedge wr_act) begin
    mem[mem_addr] <= byte_lines_o;
  end
  // a low write strobe shuts the outputs off at once
  assign rd_on = !chip_sel_one_n && chip_sel_two && !out_en_n && write_n && !off_q;
  always @(negedge rd_on) begin
    if (!$isunknown(mem[mem_addr])) last_q <= mem[mem_addr];
  end
  // released bus shows the inverse, so a stale byte never reads back
  assign byte_lines_i = byte_lines_oe ? byte_lines_o : (rd_on ? mem[mem_addr] : ~last_q);
  // alert falls at once; deselect follows inside the allowed span
  always @(posedge power_fail) begin
    alert_low_q = 1'b1;
    #(T_DESEL_NS);
    if (power_fail) off_q = 1'b1;
  end
  always @(negedge power_fail) begin
    #(T_REL_NS);
    off_q = 1'b0;
    alert_low_q = 1'b0;
  end
  // open drain with the pull-up folded in
  assign alert_n = alert_low_q ? 1'b0 : 1'b1;
endmodule : bbsp_sram_model

// ---- test/battery_backed_sram_port_bench.sv ----
`timescale 1ns/100ps
module battery_backed_sram_port_bench;
  import bbsp_pkg::*;
  // ************************************************
  // hookup
  // ************************************************
  typedef struct {logic wr; logic [ADDR_W-1:0] addr; logic [DATA_W-1:0] data;} bbsp_row_t;
  logic              clk_sys, rst, req_valid, req_ready, req_write, rsp_valid, power_ok;
  logic [ADDR_W-1:0] req_addr, mem_addr;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, bl_i, bl_o;
  logic              cs1_n, cs2, oe_n, wr_n, bl_oe, alert_n, power_fail;
  int                err_count = 0;
  int                n_compared = 0;
  bbsp_row_t         rows [8] = '{
    '{1'b1, 13'h0000, 8'h55}, '{1'b1, 13'h1FFF, 8'hAA}, '{1'b1, 13'h0AAA, 8'h01},
    '{1'b0, 13'h0000, 8'h55}, '{1'b0, 13'h1FFF, 8'hAA}, '{1'b0, 13'h0AAA, 8'h01},
    '{1'b1, 13'h0000, 8'hFE}, '{1'b0, 13'h0000, 8'hFE}};

  bbsp_ctrl #(.RECOVERY_CYCLES(20)) DUT (.clk_sys(clk_sys), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .power_ok(power_ok), .mem_addr(mem_addr),
    .chip_sel_one_n(cs1_n), .chip_sel_two(cs2), .out_en_n(oe_n), .write_n(wr_n),
    .byte_lines_i(bl_i), .byte_lines_o(bl_o), .byte_lines_oe(bl_oe), .alert_n_i(alert_n));
  bbsp_sram_model mdl (.mem_addr(mem_addr), .chip_sel_one_n(cs1_n), .chip_sel_two(cs2),
    .out_en_n(oe_n), .write_n(wr_n), .byte_lines_o(bl_o), .byte_lines_oe(bl_oe),
    .power_fail(power_fail), .byte_lines_i(bl_i), .alert_n(alert_n));

  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ************************************************
  // helpers
  // ************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  // one access, waited for under a bound
  task automatic run_op(input bbsp_row_t r);
    int t;
    t = 0;
    do begin @(posedge clk_sys); #1; t++; end while (req_ready !== 1'b1 && t < 400);
    chk(16'(req_ready), 16'h0001);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= r.wr;
    req_addr  <= r.addr;
    req_wdata <= r.data;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    t = 0;
    do begin @(posedge clk_sys); #1; t++; end while (rsp_valid !== 1'b1 && t < 40);
    if (r.wr) begin
      chk(16'(t), 16'(1 + STROBE_CYC + DATA_HOLD_CYC));
      chk(16'(mdl.mem[r.addr]), 16'(r.data));
    end else begin
      chk(16'(t), 16'(READ_CYC + 2));
      chk(16'(rsp_rdata), 16'(r.data));
    end
  endtask : run_op
  // output enable must stay off while the host drives or strobes
  always @(posedge clk_sys) begin
    if (!rst && (wr_n === 1'b0 || bl_oe === 1'b1) && oe_n !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, oe_n, 1'b1);
    end
  end
  // watchdog, well past the longest expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    summarize();
  end
  // ************************************************
  // sequence
  // ************************************************
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 13'h0000;
    req_wdata = 8'h00;
    power_fail = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(16'({cs1_n, cs2, wr_n, oe_n}), 16'h000B);
    chk(16'({bl_oe, req_ready, power_ok}), 16'h0000);
    @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i]) begin
      run_op(rows[i]);
    end
    // supply fails; a held write must never reach the pins
    @(posedge clk_sys);
    power_fail <= 1'b1;
    repeat (4) @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_addr  <= 13'h1FFF;
    req_wdata <= 8'h00;
    repeat (2000) begin
      @(posedge clk_sys);
      #1;
      chk(16'({req_ready, wr_n}), 16'h0001);
    end
    @(posedge clk_sys);
    req_valid <= 1'b0;
    power_fail <= 1'b0;
    // alert release plus recovery keeps the port closed
    repeat (140) begin
      @(posedge clk_sys);
      #1;
      chk(16'({req_ready, cs1_n, cs2}), 16'h0002);
    end
    run_op('{1'b0, 13'h1FFF, 8'hAA});
    // mid-run reset closes the port again; stored bytes survive it
    chk(16'(power_ok), 16'h0001);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk(16'({cs1_n, cs2, wr_n, oe_n, req_ready, power_ok}), 16'h002C);
    run_op('{1'b0, 13'h0000, 8'hFE});
    summarize();
  end
endmodule : battery_backed_sram_port_bench
